// ### logic/mlsc_top.sv
// low-speed control and status logic of a pluggable module
//
// How it works
// - answer the two-wire bus only while selected
// - long reset pulse restores all default settings
// - completion raises interrupt and clears pending flag
// - power-up posts the same completion interrupt
// - undriven init select reads high internally
// - init select high: wait for software enable
// - init select low: go high power directly
// - presence line pulled to ground when inserted
// - interrupt low flags fault or init completion
// - interrupt pin is open drain, pull only
// - memory map reachable over two-wire bus
`timescale 1ns/1ns
`default_nettype none
module mlsc_top
    import mlsc_pkg::*;
#(
    parameter int RESET_MIN = RESET_MIN_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // host control pins
    input  wire logic module_select_n,
    input  wire logic module_reset_n,
    input  wire logic init_control_select_i,
    input  wire logic init_control_select_driven,
    // two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe,
    // presence and interrupt pins
    output var  logic presence_n_o,
    output var  logic presence_n_oe,
    output var  logic interrupt_n_o,
    output var  logic interrupt_n_oe,
    // module internals
    input  wire logic fault_event,
    output var  logic high_power_en,
    output var  logic data_pending_flag
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mlsc_map_if map_bus ();

    mlsc_pwr_t         pwr_r;
    mlsc_pwr_t         pwr_nxt;
    logic [INIT_CNT_W-1:0] init_cnt_r;
    logic [FLG_W-1:0]  flags_r;
    logic [FLG_W-1:0]  flags_nxt;
    logic [FLG_W-1:0]  mask_r;
    logic              ctrl_hp_r;
    logic              pending_r;
    logic              pending_nxt;
    logic              tw_oe;
    logic              filt_active;

    logic              init_sel;
    logic              init_done;
    logic              in_reset;
    logic              irq;
    logic              wr_flags;
    logic              wr_mask;
    logic              wr_ctrl;
    logic [FLG_W-1:0]  flag_clr;
    logic [FLG_W-1:0]  flag_set;
    logic [7:0]        rd_status;
    logic [7:0]        rd_flags;
    logic [7:0]        rd_mask;
    logic [7:0]        rd_ctrl;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    // reset pin filter, shorter pulses are dropped
    mlsc_rst_filter #(
        .MIN_CYCLES     (RESET_MIN)
    ) u_filter (
        .clock          (clock),
        .rst_b          (rst_b),
        .module_reset_n (module_reset_n),
        .active_r       (filt_active)
    );

    // two-wire slave in front of the map
    mlsc_tw_slave u_tw (
        .clock           (clock),
        .rst_b           (rst_b),
        .module_select_n (module_select_n),
        .scl_i           (scl_i),
        .sda_i           (sda_i),
        .sda_oe_r        (tw_oe),
        .map             (map_bus.slave)
    );

    // ------------------------------------------------------------
    // pin decode and write strobes
    // ------------------------------------------------------------
    // internal pull-up: undriven select reads as software mode
    assign init_sel  = init_control_select_driven ? init_control_select_i : 1'b1;
    assign in_reset  = (pwr_r == PS_RESET) || filt_active;
    assign init_done = (pwr_r == PS_INIT) && (init_cnt_r == INIT_LAST) && !filt_active;
    assign wr_flags  = map_bus.wr && (map_bus.offset == MAP_FLAGS);
    assign wr_mask   = map_bus.wr && (map_bus.offset == MAP_MASK);
    assign wr_ctrl   = map_bus.wr && (map_bus.offset == MAP_CTRL);

    // sticky event flags, write one to clear, set wins
    assign flag_clr  = wr_flags ? map_bus.wdata[FLG_W-1:0] : FLAGS_RST;
    assign flag_set  = {fault_event && !in_reset, init_done};
    assign flags_nxt = in_reset ? FLAGS_RST : ((flags_r & ~flag_clr) | flag_set);
    assign irq       = |(flags_nxt & mask_r);

    // pending flag held from reset start until init finishes
    assign pending_nxt = in_reset ? 1'b1 : (init_done ? 1'b0 : pending_r);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    assign rd_status = {ST_PAD5, init_sel, (pwr_r == PS_HIGH), pending_r};
    assign rd_flags  = {ST_PAD, flags_r};
    assign rd_mask   = {ST_PAD, mask_r};
    assign rd_ctrl   = {CTRL_PAD, ctrl_hp_r};
    assign map_bus.rdata =
        (map_bus.offset == MAP_STATUS) ? rd_status :
        (map_bus.offset == MAP_FLAGS)  ? rd_flags  :
        (map_bus.offset == MAP_MASK)   ? rd_mask   :
        (map_bus.offset == MAP_CTRL)   ? rd_ctrl   : MAP_UNMAPPED;

    // ------------------------------------------------------------
    // power and initialization sequence
    // ------------------------------------------------------------
    // next power state
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PS_RESET: begin
                pwr_nxt = PS_INIT;
            end
            PS_INIT: begin
                if (init_done) begin
                    pwr_nxt = PS_LOW;
                end
            end
            PS_LOW: begin
                if (!init_sel) begin
                    pwr_nxt = PS_HIGH;
                end else if (ctrl_hp_r) begin
                    pwr_nxt = PS_HIGH;
                end
            end
            PS_HIGH: begin
                if (init_sel && !ctrl_hp_r) begin
                    pwr_nxt = PS_LOW;
                end
            end
            default: begin
                pwr_nxt = PS_RESET;
            end
        endcase
        if (filt_active) begin
            pwr_nxt = PS_RESET;
        end
    end

    // state and init timer; power-up starts in reset too
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pwr_r      <= PS_RESET;
            init_cnt_r <= '0;
        end else begin
            pwr_r      <= pwr_nxt;
            init_cnt_r <= (pwr_r == PS_INIT) ? init_cnt_r + 1'b1 : '0;
        end
    end

    // ------------------------------------------------------------
    // settings and flags
    // ------------------------------------------------------------
    // settings return to defaults on every reset
    always_ff @(posedge clock) begin
        if (!rst_b || in_reset) begin
            mask_r    <= MASK_RST;
            ctrl_hp_r <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_r <= map_bus.wdata[FLG_W-1:0];
            end
            if (wr_ctrl) begin
                ctrl_hp_r <= map_bus.wdata[CTRL_HP_BIT];
            end
        end
    end

    // flags and pending state
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flags_r   <= FLAGS_RST;
            pending_r <= 1'b1;
        end else begin
            flags_r   <= flags_nxt;
            pending_r <= pending_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sda_o             <= 1'b0;
            sda_oe            <= 1'b0;
            presence_n_o      <= 1'b0;
            presence_n_oe     <= 1'b1;
            interrupt_n_o     <= 1'b0;
            interrupt_n_oe    <= 1'b0;
            high_power_en     <= 1'b0;
            data_pending_flag <= 1'b1;
        end else begin
            sda_o             <= 1'b0;
            sda_oe            <= tw_oe;
            presence_n_o      <= 1'b0;
            presence_n_oe     <= 1'b1;
            interrupt_n_o     <= 1'b0;
            interrupt_n_oe    <= irq;
            high_power_en     <= (pwr_nxt == PS_HIGH);
            data_pending_flag <= pending_nxt;
        end
    end

endmodule
`default_nettype wire

// ### logic/mlsc_pkg.sv
// constants and types shared by the low-speed control block
package mlsc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 25;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int INIT_TIME_US     = 2;
    localparam int INIT_CYCLES      = INIT_TIME_US * CLK_MHZ;
    localparam int RESET_MIN_NS     = 1000;
    localparam int RESET_MIN_CYCLES =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W       = 8;
    localparam int FILT_CNT_W       = 16;

    localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES - 1);

    // ------------------------------------------------------------
    // two-wire interface
    // ------------------------------------------------------------
    // device address value is arbitrary
    localparam logic [6:0] TW_DEV_ADDR   = 7'h2A;
    localparam logic [3:0] TW_BYTE_BITS  = 4'h8;
    localparam logic [3:0] TW_LAST_BIT   = 4'h7;
    localparam logic [3:0] TW_CNT_ZERO   = 4'h0;
    localparam logic [7:0] OFFS_STEP     = 8'h01;

    // ------------------------------------------------------------
    // memory map offsets, fields and defaults
    // ------------------------------------------------------------
    localparam logic [7:0] MAP_STATUS    = 8'h00;
    localparam logic [7:0] MAP_FLAGS     = 8'h01;
    localparam logic [7:0] MAP_MASK      = 8'h02;
    localparam logic [7:0] MAP_CTRL      = 8'h03;
    localparam logic [7:0] MAP_UNMAPPED  = 8'h00;

    localparam int ST_PENDING_BIT  = 0;
    localparam int ST_HIGH_BIT     = 1;
    localparam int ST_INITSEL_BIT  = 2;
    localparam int FLG_DONE_BIT    = 0;
    localparam int FLG_FAULT_BIT   = 1;
    localparam int CTRL_HP_BIT     = 0;
    localparam int FLG_W           = 2;

    localparam logic [FLG_W-1:0] FLAGS_RST = 2'h0;
    localparam logic [FLG_W-1:0] MASK_RST  = 2'h3;
    localparam logic [5:0]       ST_PAD    = 6'h00;
    localparam logic [4:0]       ST_PAD5   = 5'h00;
    localparam logic [6:0]       CTRL_PAD  = 7'h00;

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_RESET = 2'h0,
        PS_INIT  = 2'h1,
        PS_LOW   = 2'h3,
        PS_HIGH  = 2'h2
    } mlsc_pwr_t;

    typedef enum logic [2:0] {
        TW_IDLE  = 3'h0,
        TW_DEVA  = 3'h1,
        TW_AACK  = 3'h3,
        TW_WBYTE = 3'h2,
        TW_WACK  = 3'h6,
        TW_RBYTE = 3'h7,
        TW_RACK  = 3'h5
    } mlsc_tw_t;

endpackage

// ### logic/mlsc_map_if.sv
// register access path between the two-wire slave and the map
`timescale 1ns/1ns
`default_nettype none
interface mlsc_map_if;
    logic [7:0] offset;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] rdata;

    // two-wire slave side
    modport slave (output offset, output wdata, output wr, input rdata);
    // memory map side
    modport map   (input offset, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

// ### logic/mlsc_rst_filter.sv
// glitch filter for the module reset pin
`timescale 1ns/1ns
`default_nettype none
module mlsc_rst_filter
    import mlsc_pkg::*;
#(
    parameter int MIN_CYCLES = RESET_MIN_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // pin and filtered result
    input  wire logic module_reset_n,
    output var  logic active_r
);

    localparam logic [FILT_CNT_W-1:0] MIN_LAST = FILT_CNT_W'(MIN_CYCLES);

    logic [FILT_CNT_W-1:0] cnt_r;
    logic                  reached;

    // low held past the minimum; shorter pulses never reach it
    assign reached = (cnt_r == MIN_LAST);

    // count consecutive low samples, saturating
    always_ff @(posedge clock) begin
        if (!rst_b || module_reset_n) begin
            cnt_r    <= '0;
            active_r <= 1'b0;
        end else begin
            if (!reached) begin
                cnt_r <= cnt_r + 1'b1;
            end
            active_r <= reached;
        end
    end

endmodule
`default_nettype wire

// ### logic/mlsc_tw_slave.sv
// two-wire serial slave gated by module select
`timescale 1ns/1ns
`default_nettype none
module mlsc_tw_slave
    import mlsc_pkg::*;
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst_b,
    // select and bus lines
    input  wire logic   module_select_n,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    output var  logic   sda_oe_r,
    // map access
    mlsc_map_if.slave   map
);

    mlsc_tw_t   st_r;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       rw_r;
    logic       first_r;
    logic       ack_r;
    logic [7:0] offs_r;

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic byte_in;
    logic addr_hit;
    logic offs_load;
    logic data_wr;

    // line events from sampled levels
    assign scl_rise  = scl_i & ~scl_q;
    assign scl_fall  = ~scl_i & scl_q;
    assign start_c   = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c    = scl_i & scl_q & ~sda_q & sda_i;
    assign byte_in   = scl_fall && (cnt_r == TW_BYTE_BITS);
    assign addr_hit  = (sh_r[7:1] == TW_DEV_ADDR);
    assign offs_load = (st_r == TW_WBYTE) && byte_in && first_r;
    assign data_wr   = (st_r == TW_WBYTE) && byte_in && !first_r;
    assign map.offset = offs_r;
    assign map.wdata  = sh_r;
    assign map.wr     = data_wr;

    // previous line levels
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // offset pointer, auto-increment after each data byte
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            offs_r <= '0;
        end else if (offs_load) begin
            offs_r <= sh_r;
        end else if (data_wr || (st_r == TW_RBYTE && scl_fall && cnt_r == TW_LAST_BIT)) begin
            offs_r <= offs_r + OFFS_STEP;
        end
    end

    // byte protocol; deselect drops the transfer and frees the line
    always_ff @(posedge clock) begin
        if (!rst_b || module_select_n || stop_c) begin
            st_r     <= TW_IDLE;
            sda_oe_r <= 1'b0;
            cnt_r    <= TW_CNT_ZERO;
            sh_r     <= '0;
            rw_r     <= 1'b0;
            first_r  <= 1'b0;
            ack_r    <= 1'b0;
        end else if (start_c) begin
            st_r     <= TW_DEVA;
            sda_oe_r <= 1'b0;
            cnt_r    <= TW_CNT_ZERO;
            first_r  <= 1'b1;
        end else begin
            case (st_r)
                TW_DEVA, TW_WBYTE: begin
                    if (scl_rise) begin
                        sh_r  <= {sh_r[6:0], sda_i};
                        cnt_r <= cnt_r + 1'b1;
                    end else if (byte_in) begin
                        if (st_r == TW_DEVA && !addr_hit) begin
                            st_r <= TW_IDLE;
                        end else begin
                            sda_oe_r <= 1'b1;
                            st_r     <= (st_r == TW_DEVA) ? TW_AACK : TW_WACK;
                            rw_r     <= (st_r == TW_DEVA) ? sh_r[0] : rw_r;
                            first_r  <= (st_r == TW_DEVA) ? first_r : 1'b0;
                        end
                    end
                end
                TW_AACK, TW_WACK: begin
                    if (scl_fall) begin
                        cnt_r <= TW_CNT_ZERO;
                        if (st_r == TW_AACK && rw_r) begin
                            st_r     <= TW_RBYTE;
                            sh_r     <= {map.rdata[6:0], 1'b0};
                            sda_oe_r <= ~map.rdata[7];
                        end else begin
                            st_r     <= TW_WBYTE;
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                TW_RBYTE: begin
                    if (scl_fall) begin
                        if (cnt_r == TW_LAST_BIT) begin
                            sda_oe_r <= 1'b0;
                            st_r     <= TW_RACK;
                        end else begin
                            sda_oe_r <= ~sh_r[7];
                            sh_r     <= {sh_r[6:0], 1'b0};
                            cnt_r    <= cnt_r + 1'b1;
                        end
                    end
                end
                TW_RACK: begin
                    if (scl_rise) begin
                        ack_r <= ~sda_i;
                    end else if (scl_fall) begin
                        cnt_r    <= TW_CNT_ZERO;
                        st_r     <= ack_r ? TW_RBYTE : TW_IDLE;
                        sh_r     <= {map.rdata[6:0], 1'b0};
                        sda_oe_r <= ack_r & ~map.rdata[7];
                    end
                end
                default: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### verif/mlsc_properties.sv
// pin-level assertions for the low-speed control block
`timescale 1ns/1ns
`default_nettype none
module mlsc_properties
    import mlsc_pkg::*;
#(
    parameter int RESET_MIN = RESET_MIN_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // host control pins
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic init_control_select_i,
    input wire logic init_control_select_driven,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // presence and interrupt pins
    input wire logic presence_n_o,
    input wire logic presence_n_oe,
    input wire logic interrupt_n_o,
    input wire logic interrupt_n_oe,
    // module internals
    input wire logic fault_event,
    input wire logic high_power_en,
    input wire logic data_pending_flag
);
    // ----------------
    // helpers
    // ----------------
    logic [15:0] low_cnt_r;
    logic        hw_init;

    // hardware-controlled entry selected
    assign hw_init = init_control_select_driven && !init_control_select_i;

    // consecutive low samples of the reset pin, saturating
    always_ff @(posedge clock) begin
        if (module_reset_n) begin
            low_cnt_r <= 16'h0000;
        end else if (low_cnt_r != 16'hFFFF) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sel_gate_a: assert property (module_select_n [*3] |-> !sda_oe)
        else $error("data line pulled while deselected");
    long_rst_a: assert property (!module_reset_n && low_cnt_r == 16'(RESET_MIN) |->
        ##[1:3] (data_pending_flag && !interrupt_n_oe)) else $error("long reset ignored");
    short_rst_a: assert property (!data_pending_flag && low_cnt_r < 16'(RESET_MIN - 1)
        |=> !data_pending_flag) else $error("short reset pulse acted");
    done_irq_a: assert property ($fell(data_pending_flag) |-> interrupt_n_oe)
        else $error("completion without interrupt");
    pwr_up_a: assert property ($rose(rst_b) |->
        data_pending_flag [*8] ##[40:50] !data_pending_flag) else $error("power-up completion");
    hw_init_a: assert property ($fell(data_pending_flag) && hw_init |->
        ##[0:3] high_power_en) else $error("no high power under hardware control");
    sw_init_a: assert property ($fell(data_pending_flag) && !hw_init |->
        !high_power_en [*4]) else $error("high power without software enable");
    pend_low_a: assert property (data_pending_flag && $past(data_pending_flag, 2)
        |-> !high_power_en) else $error("high power while pending");
    pins_od_a: assert property (presence_n_oe && !presence_n_o && !interrupt_n_o
        && !sda_o) else $error("open-drain pin driven high");
    fault_irq_a: assert property (fault_event && !data_pending_flag |->
        ##[1:2] interrupt_n_oe) else $error("fault without interrupt");

    // main scenarios
    cover property ($fell(data_pending_flag));
    cover property ($rose(high_power_en));
    cover property ($rose(sda_oe));
endmodule
`default_nettype wire

// ### verif/mlsc_host_model.sv
// two-wire host master standing in for the host board controller
`timescale 1ns/1ns
`default_nettype none
module mlsc_host_model
    import mlsc_pkg::*;
(
    // clock
    input  wire logic clock,
    // bus lines
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_pull
);
    // bus idle: clock high, data released to its pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge clock);
    endtask

    // one bit: data set while clock low, sampled at end of high phase
    task automatic bit_io(input logic b, output logic r);
        @(negedge clock);
        sda_pull = !b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask

    // byte msb first plus acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, ack);
    endtask

    // low phase first so a repeated start sees the line released
    task automatic start();
        @(negedge clock);
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        @(negedge clock);
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b0;
        half();
    endtask

    // address, offset, one data byte
    task automatic wr(input logic [7:0] off, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2;
        start();
        xfer({TW_DEV_ADDR, 1'b0}, 1'b1, q, a0);
        xfer(off, 1'b1, q, a1);
        xfer(d, 1'b1, q, a2);
        stop();
        ok = !(a0 || a1 || a2);
    endtask

    // set offset, repeated start, one byte read and refused
    task automatic rd(input logic [7:0] off, output logic [7:0] q, output logic ok);
        logic [7:0] x;
        logic       a0, a1, a2, nk;
        start();
        xfer({TW_DEV_ADDR, 1'b0}, 1'b1, x, a0);
        xfer(off, 1'b1, x, a1);
        start();
        xfer({TW_DEV_ADDR, 1'b1}, 1'b1, x, a2);
        xfer(8'hFF, 1'b1, q, nk);
        stop();
        ok = !(a0 || a1 || a2);
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the low-speed control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mlsc_pkg::*;
    localparam int RMIN = 3;

    logic       clock, rst_b, module_select_n, module_reset_n, fault_event;
    logic       init_sel, init_drv, scl, sda_pull, sda_o, sda_oe, ok;
    logic       presence_n_o, presence_n_oe, interrupt_n_o, interrupt_n_oe;
    logic       high_power_en, data_pending_flag;
    wire        sda_line, int_line, presence_line;
    logic [7:0] q;
    int         err_count, comparisons, n;

    // host-side pull-ups resolve the open-drain lines
    assign sda_line      = !(sda_pull || (sda_oe && !sda_o));
    assign int_line      = !(interrupt_n_oe && !interrupt_n_o);
    assign presence_line = !(presence_n_oe && !presence_n_o);

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    mlsc_top #(.RESET_MIN(RMIN)) uut (
        .clock(clock), .rst_b(rst_b), .module_select_n(module_select_n),
        .module_reset_n(module_reset_n), .init_control_select_i(init_sel),
        .init_control_select_driven(init_drv), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .presence_n_o(presence_n_o),
        .presence_n_oe(presence_n_oe), .interrupt_n_o(interrupt_n_o),
        .interrupt_n_oe(interrupt_n_oe), .fault_event(fault_event),
        .high_power_en(high_power_en), .data_pending_flag(data_pending_flag));

    mlsc_host_model host (.clock(clock), .sda(sda_line), .scl(scl), .sda_pull(sda_pull));

    task automatic conclude();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // status is ignored until the pending flag drops
    task automatic wait_done();
        n = 0;
        while (data_pending_flag !== 1'b0) begin
            @(negedge clock);
            n++;
            if (n > 500) begin
                err_count++;
                $display("[FAIL] %0t completion wait timed out", $time);
                conclude();
            end
        end
        chk({7'h00, n >= INIT_CYCLES && n <= INIT_CYCLES + 4}, 8'h01);
    endtask

    task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
        host.rd(off, q, ok);
        chk({7'h00, ok}, 8'h01);
        chk(q, exp);
    endtask

    // power-up reset; init select only changes with the module removed
    task automatic power(input logic drv, input logic val);
        rst_b = 1'b0;
        init_drv = drv;
        init_sel = val;
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
    endtask

    // main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        module_select_n = 1'b0;
        module_reset_n = 1'b1;
        fault_event = 1'b0;
        power(1'b0, 1'b0);
        chk({6'h00, data_pending_flag, presence_line}, 8'h02);
        wait_done();
        chk({6'h00, int_line, high_power_en}, 8'h00);
        rd_chk(MAP_STATUS, 8'h04);
        rd_chk(MAP_FLAGS, 8'h01);
        rd_chk(MAP_MASK, 8'h03);
        host.wr(MAP_FLAGS, 8'h01, ok);
        chk({6'h00, ok, int_line}, 8'h03);
        module_select_n = 1'b1;
        host.rd(MAP_STATUS, q, ok);
        chk({7'h00, ok}, 8'h00);
        module_select_n = 1'b0;
        host.wr(MAP_CTRL, 8'h01, ok);
        repeat (3) @(negedge clock);
        chk({6'h00, ok, high_power_en}, 8'h03);
        rd_chk(MAP_STATUS, 8'h06);
        fault_event = 1'b1;
        @(negedge clock);
        fault_event = 1'b0;
        repeat (2) @(negedge clock);
        chk({7'h00, int_line}, 8'h00);
        rd_chk(MAP_FLAGS, 8'h02);
        host.wr(MAP_FLAGS, 8'h02, ok);
        chk({7'h00, int_line}, 8'h01);
        module_reset_n = 1'b0;
        repeat (RMIN - 1) @(negedge clock);
        module_reset_n = 1'b1;
        repeat (4) @(negedge clock);
        chk({6'h00, data_pending_flag, high_power_en}, 8'h01);
        module_reset_n = 1'b0;
        repeat (RMIN + 3) @(negedge clock);
        chk({5'h00, data_pending_flag, high_power_en, int_line}, 8'h05);
        module_reset_n = 1'b1;
        wait_done();
        chk({6'h00, int_line, high_power_en}, 8'h00);
        rd_chk(MAP_CTRL, 8'h00);
        power(1'b1, 1'b0);
        wait_done();
        repeat (3) @(negedge clock);
        chk({7'h00, high_power_en}, 8'h01);
        rd_chk(MAP_STATUS, 8'h02);
        conclude();
    end
endmodule

bind mlsc_top mlsc_properties #(.RESET_MIN(RESET_MIN)) props (
    .clock(clock), .rst_b(rst_b), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .init_control_select_i(init_control_select_i),
    .init_control_select_driven(init_control_select_driven), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .presence_n_o(presence_n_o),
    .presence_n_oe(presence_n_oe), .interrupt_n_o(interrupt_n_o),
    .interrupt_n_oe(interrupt_n_oe), .fault_event(fault_event),
    .high_power_en(high_power_en), .data_pending_flag(data_pending_flag));
`default_nettype wire
